//--- nvm_host_pkg.sv
/*
 * Shared constants and carrier types for the parallel nonvolatile memory
 * controller: timing figures, derived cycle counts, request and pin bundles.
 * Assumes a single 20 MHz core clock.
 */
package nvm_host_pkg;

	// ------------------------------------------------------------------
	// clock and timing
	// ------------------------------------------------------------------
	localparam int CLK_PERIOD_NS = 50;
	localparam int PRECHARGE_MIN_TIME_NS = 60; // precharge_min_time
	localparam int SELECT_ACTIVE_MIN_NS = 120; // select_active_window, low bound
	localparam int SELECT_ACTIVE_MAX_NS = 2000; // select_active_window, high bound
	localparam int WRITE_PULSE_MIN_NS = 40;
	localparam int POWER_UP_WAIT_NS = 1000; // supply good to first access

	// least times round up, longest time rounds down; never below one cycle
	localparam int PRECHARGE_CYC = (PRECHARGE_MIN_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int ACTIVE_MIN_CYC = (SELECT_ACTIVE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int ACTIVE_MAX_CYC = SELECT_ACTIVE_MAX_NS / CLK_PERIOD_NS;
	localparam int WRITE_PULSE_CYC = (WRITE_PULSE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int POWER_UP_CYC = (POWER_UP_WAIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	// ------------------------------------------------------------------
	// widths and row geometry
	// ------------------------------------------------------------------
	localparam int ADDR_W = 13;
	localparam int DATA_W = 8;
	localparam int ROW_BYTE_BITS = 2; // a row spans four bytes
	localparam int ROW_W = ADDR_W - ROW_BYTE_BITS;

	// reset levels of the pin bundle
	localparam logic PIN_IDLE_HIGH = 1'b1;

	// ------------------------------------------------------------------
	// carriers
	// ------------------------------------------------------------------
	typedef struct packed {
		logic write;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
	} req_t;

	typedef struct packed {
		logic sel_n;
		logic we_n;
		logic oe_n;
		logic sel_oe;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] dq;
		logic dq_oe;
	} pins_t;

endpackage : nvm_host_pkg

//--- nvm_sync2.sv
/*
 * Two-flop synchroniser for a bundle of pin levels.
 * Assumes the inputs are asynchronous levels; the first stage feeds only the second.
 */
`timescale 1ns/10ps
module nvm_sync2 #(
	parameter int W = 1
) (
	input wire logic i_clk,
	input wire logic i_rstn,
	input wire logic [W-1:0] i_async,
	output logic [W-1:0] o_sync
);
	logic [W-1:0] stage1;

	// ------------------------------------------------------------------
	// two stages, constant reset value
	// ------------------------------------------------------------------
	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			stage1 <= '0;
			o_sync <= '0;
		end else begin
			stage1 <= i_async;
			o_sync <= stage1;
		end
	end
endmodule : nvm_sync2

//--- nvm_host.sv
/*
 * Controller that drives a bytewide nonvolatile memory over its asynchronous
 * parallel pins: select, write enable, output enable, address and data.
 * Assumes a 20 MHz clock, a request/accept handshake from local logic and a
 * supply-good level coming from an outside voltage monitor.
 */
`timescale 1ns/10ps
module nvm_host
	import nvm_host_pkg::*;
#(
	parameter int ACTIVE_CYC = ACTIVE_MIN_CYC + 1,
	parameter int PRE_CYC = PRECHARGE_CYC,
	parameter int PWR_CYC = POWER_UP_CYC
) (
	input wire logic I_CORE_CLK,
	input wire logic I_RSTN,
	input wire logic I_SUPPLY_GOOD,
	input wire logic I_REQ_VALID,
	input wire req_t I_REQ,
	output logic O_REQ_READY,
	output logic O_RD_VALID,
	output logic [DATA_W-1:0] O_RD_DATA,
	output logic O_ROW_VALID,
	output logic [ROW_W-1:0] O_ROW,
	output logic O_SEL_N,
	output logic O_SEL_OE,
	output logic O_WE_N,
	output logic O_OE_N,
	output logic [ADDR_W-1:0] O_ADDR,
	output logic [DATA_W-1:0] O_DQ,
	output logic O_DQ_OE,
	input wire logic [DATA_W-1:0] I_DQ
);
	// clamp the active window into the legal range
	// out-of-range settings are pulled in quietly rather than refused
	localparam int ACT = (ACTIVE_CYC < ACTIVE_MIN_CYC) ? ACTIVE_MIN_CYC :
		((ACTIVE_CYC > ACTIVE_MAX_CYC) ? ACTIVE_MAX_CYC : ACTIVE_CYC);
	localparam int CW = 12;

	// one flop per phase, so a stray code is easy to spot
	typedef enum logic [3:0] {
		ST_OFF = 4'b0001,
		ST_IDLE = 4'b0010,
		ST_ACTIVE = 4'b0100,
		ST_PRE = 4'b1000
	} state_t;

	state_t state;
	logic [CW-1:0] cnt;
	logic [CW-1:0] pwr_cnt;
	logic supply_ok;
	logic [DATA_W-1:0] dq_sync;
	logic win_end;
	pins_t pins;
	logic take;

	// row index of a byte address
	function automatic logic [ROW_W-1:0] row_of(input logic [ADDR_W-1:0] a);
		row_of = a[ADDR_W-1:ROW_BYTE_BITS];
	endfunction : row_of

	// ------------------------------------------------------------------
	// pin synchronisers
	// ------------------------------------------------------------------
	nvm_sync2 #(.W(1 + DATA_W)) nvm_sync2_i (
		.i_clk(I_CORE_CLK),
		.i_rstn(I_RSTN),
		.i_async({I_SUPPLY_GOOD, I_DQ}),
		.o_sync({supply_ok, dq_sync})
	);

	// accept only in idle with supply good; the power-up wait is served only on the way out of off
	// the memory itself never refuses, so all supply gating lives here
	assign take = (state == ST_IDLE) && supply_ok && I_REQ_VALID;
	assign O_REQ_READY = (state == ST_IDLE) && supply_ok;
	// last cycle of the select-low window
	assign win_end = (state == ST_ACTIVE) && (cnt == CW'(ACT - 1));

	// ------------------------------------------------------------------
	// power-up wait after supply good
	// ------------------------------------------------------------------
	// the memory reports no readiness, so its start-up time is counted here
	always_ff @(posedge I_CORE_CLK or negedge I_RSTN) begin
		if (!I_RSTN) begin
			pwr_cnt <= '0;
		end else if (!supply_ok) begin
			pwr_cnt <= '0;
		end else if (pwr_cnt != CW'(PWR_CYC)) begin
			pwr_cnt <= pwr_cnt + 1'b1;
		end
	end

	// ------------------------------------------------------------------
	// access / precharge sequencer
	// ------------------------------------------------------------------
	// an access never aborts: once select falls the window is served in full
	// precharge ending with supply bad parks the sequencer in off
	always_ff @(posedge I_CORE_CLK or negedge I_RSTN) begin
		if (!I_RSTN) begin
			state <= ST_OFF;
			cnt <= '0;
		end else begin
			unique case (state)
				ST_OFF: begin
					if (supply_ok && pwr_cnt == CW'(PWR_CYC)) begin
						state <= ST_PRE; // start with a full precharge
						cnt <= '0;
					end
				end
				ST_IDLE: begin
					if (!supply_ok) begin
						state <= ST_OFF;
					end else if (take) begin
						state <= ST_ACTIVE;
						cnt <= '0;
					end
				end
				ST_ACTIVE: begin
					if (win_end) begin
						state <= ST_PRE;
						cnt <= '0;
					end else begin
						cnt <= cnt + 1'b1;
					end
				end
				ST_PRE: begin
					if (cnt >= CW'(PRE_CYC - 1)) begin
						state <= supply_ok ? ST_IDLE : ST_OFF;
						cnt <= '0;
					end else begin
						cnt <= cnt + 1'b1;
					end
				end
				default: begin
					state <= ST_OFF;
					cnt <= '0;
				end
			endcase
		end
	end

	// ------------------------------------------------------------------
	// pin drive, all from flops
	// ------------------------------------------------------------------
	// address and data are set with select falling and held through the window
	always_ff @(posedge I_CORE_CLK or negedge I_RSTN) begin
		if (!I_RSTN) begin
			pins.sel_n <= PIN_IDLE_HIGH;
			pins.sel_oe <= 1'b0;
			pins.we_n <= PIN_IDLE_HIGH;
			pins.oe_n <= PIN_IDLE_HIGH;
			pins.addr <= '0;
			pins.dq <= '0;
			pins.dq_oe <= 1'b0;
		end else begin
			pins.sel_oe <= 1'b1;
			if (take) begin
				pins.sel_n <= 1'b0;
				pins.addr <= I_REQ.addr;
				pins.dq <= I_REQ.wdata;
				pins.dq_oe <= I_REQ.write;
				pins.we_n <= !I_REQ.write; // select-controlled write
				pins.oe_n <= I_REQ.write;
			end else if (win_end) begin
				pins.sel_n <= 1'b1;
				pins.we_n <= 1'b1;
				pins.oe_n <= 1'b1;
				pins.dq_oe <= 1'b0;
			end else if (state != ST_ACTIVE) begin
				pins.sel_n <= 1'b1;
				pins.we_n <= 1'b1;
				pins.oe_n <= 1'b1;
				pins.dq_oe <= 1'b0;
			end
		end
	end

	// bundle fans out to the pins; every bit is a flop output
	assign O_SEL_N = pins.sel_n;
	assign O_SEL_OE = pins.sel_oe;
	assign O_WE_N = pins.we_n;
	assign O_OE_N = pins.oe_n;
	assign O_ADDR = pins.addr;
	assign O_DQ = pins.dq;
	assign O_DQ_OE = pins.dq_oe;

	// ------------------------------------------------------------------
	// read capture and row wear report
	// ------------------------------------------------------------------
	// data sampled at window end; the sync delay is covered by the window of at least 3 cycles
	// a read that ends while supply drops still reports its byte
	always_ff @(posedge I_CORE_CLK or negedge I_RSTN) begin
		if (!I_RSTN) begin
			O_RD_VALID <= 1'b0;
			O_RD_DATA <= '0;
			O_ROW_VALID <= 1'b0;
			O_ROW <= '0;
		end else begin
			O_RD_VALID <= 1'b0;
			O_ROW_VALID <= 1'b0;
			if (take) begin
				O_ROW <= row_of(I_REQ.addr);
				O_ROW_VALID <= 1'b1;
			end
			if (win_end) begin
				O_RD_VALID <= !pins.oe_n;
				O_RD_DATA <= dq_sync;
			end
		end
	end
endmodule : nvm_host

//--- nvm_host_asserts.sv
/* pin checker for nvm_host: select timing, row report, supply gating.
 * assumes a bind from the bench and the single core clock */
`timescale 1ns/10ps
module nvm_host_asserts
	import nvm_host_pkg::*;
#(
	parameter int ACTIVE_CYC = 4,
	parameter int PRE_CYC = 2
) (
	input wire logic I_CORE_CLK,
	input wire logic I_RSTN,
	input wire logic I_SUPPLY_GOOD,
	input wire logic I_REQ_VALID,
	input wire req_t I_REQ,
	input wire logic O_REQ_READY,
	input wire logic O_RD_VALID,
	input wire logic O_ROW_VALID,
	input wire logic [ROW_W-1:0] O_ROW,
	input wire logic O_SEL_N,
	input wire logic O_OE_N,
	input wire logic [ADDR_W-1:0] O_ADDR
);
	// ------------------------------------------------
	// select run lengths
	// ------------------------------------------------
	logic [7:0] lo;
	logic [7:0] hi;
	wire take = I_REQ_VALID && O_REQ_READY;
	// high count saturates so a long idle never wraps
	always_ff @(posedge I_CORE_CLK or negedge I_RSTN) begin
		if (!I_RSTN) begin
			lo <= 8'h00;
			hi <= 8'hff;
		end else begin
			lo <= O_SEL_N ? 8'h00 : lo + 8'h01;
			hi <= !O_SEL_N ? 8'h00 : (hi == 8'hff ? hi : hi + 8'h01);
		end
	end
	default clocking cb @(posedge I_CORE_CLK); endclocking
	default disable iff (!I_RSTN);
	property p_take; take |=> ($fell(O_SEL_N) && O_ROW_VALID); endproperty
	a_take: assert property (p_take) else $error("select fall late");
	property p_addr; $fell(O_SEL_N) |-> O_ADDR == $past(I_REQ.addr, 1); endproperty
	a_addr: assert property (p_addr) else $error("address wrong at fall");
	property p_row; O_ROW_VALID |-> O_ROW == O_ADDR[ADDR_W-1:ROW_BYTE_BITS]; endproperty
	a_row: assert property (p_row) else $error("row index wrong");
	property p_low; $rose(O_SEL_N) |-> lo == ACTIVE_CYC; endproperty
	a_low: assert property (p_low) else $error("select low time wrong");
	property p_pre; $fell(O_SEL_N) |-> hi > PRE_CYC; endproperty
	a_pre: assert property (p_pre) else $error("precharge too short");
	property p_sup; (!I_SUPPLY_GOOD) [*3] |-> !O_REQ_READY; endproperty
	a_sup: assert property (p_sup) else $error("ready with bad supply");
	property p_off; (!I_SUPPLY_GOOD) [*8] |-> O_SEL_N; endproperty
	a_off: assert property (p_off) else $error("select low with bad supply");
	property p_rd; $rose(O_SEL_N) && !$past(O_OE_N) |-> O_RD_VALID; endproperty
	a_rd: assert property (p_rd) else $error("read not reported");
	c_rd: cover property ($rose(O_RD_VALID));
	c_b2b: cover property ($rose(O_SEL_N) ##3 $fell(O_SEL_N));
	c_off: cover property ((!I_SUPPLY_GOOD) [*8]);
endmodule : nvm_host_asserts

//--- nvm_mem_model.sv
/* behavioural memory on the far side of the pins.
 * assumes select already resolved with its pullup */
`timescale 1ns/10ps
module nvm_mem_model
	import nvm_host_pkg::*;
(
	input wire logic i_sel_n,
	input wire logic i_we_n,
	input wire logic i_oe_n,
	input wire logic [ADDR_W-1:0] i_addr,
	input wire logic [DATA_W-1:0] i_dq,
	output logic [DATA_W-1:0] o_dq
);
	logic [DATA_W-1:0] mem [0:(1<<ADDR_W)-1];
	logic [ADDR_W-1:0] lat = '0;
	logic [DATA_W-1:0] wd;
	logic wr = 1'b0;
	int wear [0:(1<<ROW_W)-1];
	// sample address 1 ns late and data 21 ns late: all pins move on one clock edge
	always @(negedge i_sel_n) begin
		#1;
		lat = i_addr;
		wr = !i_we_n;
		wear[i_addr[ADDR_W-1:ROW_BYTE_BITS]]++;
		#20;
		wd = i_dq;
	end
	// the cycle ends and precharge begins only on the rise
	always @(posedge i_sel_n) begin
		if (wr)
			mem[lat] = wd;
		wr = 1'b0;
	end
	// released bus shows the inverse, never a stale copy
	assign o_dq = (!i_sel_n && !i_oe_n && !wr) ? mem[lat] : ~mem[lat];
endmodule : nvm_mem_model

//--- nvm_host_test.sv
/* bench for nvm_host: requests, supply loss, pin timing.
 * assumes nvm_mem_model beyond the pins and a pullup on select */
`timescale 1ns/10ps
module nvm_host_test
	import nvm_host_pkg::*;
;
	localparam int ACT = 4;
	localparam int PRE = 2;
	logic clk = 1'b0;
	logic rstn = 1'b0;
	logic sup = 1'b1;
	logic vld = 1'b0;
	req_t req = '0;
	logic ready, rd_valid, row_valid, sel_n, sel_oe, we_n, oe_n, dq_oe;
	logic [DATA_W-1:0] rd_data, dq, mdq;
	logic [ROW_W-1:0] row;
	logic [ADDR_W-1:0] addr;
	int bad_count = 0;
	int check_count = 0;
	int cyc = 0;
	int nf = 0;
	time tfall = 0;
	time gap = 0;
	wire sel_w = sel_oe ? sel_n : 1'b1;
	wire [DATA_W-1:0] dq_w = dq_oe ? dq : mdq;
	nvm_host #(.ACTIVE_CYC(ACT), .PRE_CYC(PRE), .PWR_CYC(2)) nvm_host_i (
		.I_CORE_CLK(clk), .I_RSTN(rstn), .I_SUPPLY_GOOD(sup), .I_REQ_VALID(vld),
		.I_REQ(req), .O_REQ_READY(ready), .O_RD_VALID(rd_valid), .O_RD_DATA(rd_data),
		.O_ROW_VALID(row_valid), .O_ROW(row), .O_SEL_N(sel_n), .O_SEL_OE(sel_oe),
		.O_WE_N(we_n), .O_OE_N(oe_n), .O_ADDR(addr), .O_DQ(dq), .O_DQ_OE(dq_oe),
		.I_DQ(dq_w));
	nvm_mem_model nvm_mem_model_i (.i_sel_n(sel_w), .i_we_n(we_n), .i_oe_n(oe_n),
		.i_addr(addr), .i_dq(dq_w), .o_dq(mdq));
	// ------------------------------------------------
	// clock, watchdog, select fall monitor
	// ------------------------------------------------
	initial forever #25 clk = ~clk;
	always @(posedge clk) begin
		cyc++;
		if (cyc == 5000) begin
			bad_count++;
			stop_test();
		end
	end
	always @(negedge sel_w) begin
		gap = $time - tfall;
		tfall = $time;
		nf++;
	end
	task check(input logic [15:0] seen, input logic [15:0] exp);
		check_count++;
		if (seen !== exp) begin
			bad_count++;
			$display("mismatch at %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : check
	task stop_test();
		$display("checks %0d mismatches %0d", check_count, bad_count);
		if (bad_count == 0 && check_count > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : stop_test
	// one access; the request is scrambled right after the take
	task access(input logic w, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
		int n;
		req = '{w, a, d};
		vld = 1'b1;
		n = 0;
		@(negedge clk);
		while (ready !== 1'b1 && n < 100) begin
			@(negedge clk);
			n++;
		end
		check(16'(n < 100), 16'h0001);
		@(posedge clk);
		#5;
		vld = 1'b0;
		req = ~req;
		@(negedge clk);
		check({sel_n, row_valid, row}, {2'b01, a[ADDR_W-1:ROW_BYTE_BITS]});
		repeat (ACT) @(negedge clk);
		check({sel_n, oe_n, we_n, rd_valid}, {3'b111, !w});
		if (!w)
			check(rd_data, d);
		@(posedge clk);
		#5;
	endtask : access
	// writes across a row boundary and the top byte, then reads back
	task t_rw();
		logic [ADDR_W-1:0] al [4];
		al = '{13'h0003, 13'h0004, 13'h1fff, 13'h0000};
		foreach (al[i])
			access(1'b1, al[i], al[i][7:0] ^ 8'h5a);
		foreach (al[i])
			access(1'b0, al[i], al[i][7:0] ^ 8'h5a);
	endtask : t_rw
	// read straight after a write, at the shortest legal spacing
	task t_b2b();
		access(1'b1, 13'h0800, 8'ha5);
		access(1'b0, 13'h0800, 8'ha5);
		check(16'(gap), 16'((1 + ACT + PRE) * CLK_PERIOD_NS));
	endtask : t_b2b
	// supply loss refuses requests and keeps select high
	task t_supply();
		int n0;
		sup = 1'b0;
		repeat (4) @(posedge clk);
		#5;
		check(ready, 1'b0);
		n0 = nf;
		access_try();
		check(16'(nf - n0), 16'h0000);
		sup = 1'b1;
		@(posedge clk);
		#5;
		access(1'b0, 13'h0004, 8'h5e);
	endtask : t_supply
	task access_try();
		req = '{1'b0, 13'h0010, 8'h00};
		vld = 1'b1;
		repeat (12) @(posedge clk);
		#5;
		vld = 1'b0;
	endtask : access_try
	initial begin
		repeat (6) @(posedge clk);
		#5;
		check({sel_oe, sel_n, we_n, oe_n, dq_oe, ready}, 6'h1c);
		rstn = 1'b1;
		t_rw();
		t_b2b();
		t_supply();
		stop_test();
	end
endmodule : nvm_host_test
bind nvm_host nvm_host_asserts #(.ACTIVE_CYC(ACT), .PRE_CYC(PRE_CYC)) nvm_host_asserts_i (
	.I_CORE_CLK(I_CORE_CLK), .I_RSTN(I_RSTN), .I_SUPPLY_GOOD(I_SUPPLY_GOOD),
	.I_REQ_VALID(I_REQ_VALID), .I_REQ(I_REQ), .O_REQ_READY(O_REQ_READY),
	.O_RD_VALID(O_RD_VALID), .O_ROW_VALID(O_ROW_VALID), .O_ROW(O_ROW),
	.O_SEL_N(O_SEL_N), .O_OE_N(O_OE_N), .O_ADDR(O_ADDR));
